// ### logic/pcw_csr_bank.sv
// Wishbone register window of the endpoint: config space pass-through and CSR bank.
// Assumes a classic Wishbone master and core-side status inputs on the core clock.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Write data holds N+2 upper, N+2 lower, N upper, N lower bytes.
// - Config reads return lower N first, then lower and upper N+2.
// - CSR reads use the same byte order as writes.
// - Bit 7 is the most significant bit of every byte.
// - Status bits 23:20 show lane sync; unused lanes reserved.
// - Status bits 19:16 hold sticky connection results, cleared on write.
// - Status bits 15:12 show receive electrical idle; unused lanes reserved.
// - Status bits 11:7 hold the link training state code.
// - Status bits 6:3 are inactive, init, active and link-up flags.
// - Control resets to zero; bits 21:18 force loopback per lane.
// - Control bit 17 selects debug bypass of link and transaction checks.
// - Control bits 16..12 beacon, force sync, idle, connection, scrambler off.
// - Control bit 11 sets disable-scrambling in training sets.
// - Control bits 10..0 steer training states; bit 3 reserved.
// - Three frequency registers: header 17:11, data 10:0, configured defaults.
// - Link config access goes first; Wishbone termination waits.
module pcw_csr_bank
  import pcw_pkg::*;
#(
  parameter int          LANES       = 4,
  parameter logic [31:0] ACK_DEFAULT = 32'h0000_0000,
  parameter logic [31:0] PFRQ_DEF    = 32'h0000_0000,
  parameter logic [31:0] NFRQ_DEF    = 32'h0000_0000,
  parameter logic [31:0] CFRQ_DEF    = 32'h0000_0000,
  parameter logic [31:0] TMR_DEFAULT = 32'h0000_0000
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [12:0]      i_wb_adr,
  input  wire logic [31:0]      i_wb_dat,
  output var  logic [31:0]      o_wb_dat,
  output var  logic             o_wb_ack,
  input  wire logic             i_link_cfg_busy,
  input  wire logic [15:0]      i_cfg_rd_lo,
  input  wire logic [15:0]      i_cfg_rd_hi,
  output var  logic             o_cfg_wr,
  output var  logic [9:0]       o_cfg_wr_adr,
  output var  logic [31:0]      o_cfg_wr_dat,
  output var  logic [3:0]       o_cfg_wr_sel,
  output var  logic [9:0]       o_cfg_rd_adr,
  input  wire logic [LANES-1:0] i_lane_sync,
  input  wire logic [LANES-1:0] i_conn_detect,
  input  wire logic [LANES-1:0] i_rx_elec_idle,
  input  wire logic [4:0]       i_ltssm_state,
  input  wire logic [3:0]       i_dl_state,
  output var  logic [31:0]      o_force_ctrl,
  output var  logic [31:0]      o_ack_fts_skp,
  output var  logic [31:0]      o_posted_frq,
  output var  logic [31:0]      o_nonposted_frq,
  output var  logic [31:0]      o_completion_frq,
  output var  logic [11:0]      o_fc_timer,
  output var  logic [7:0]       o_link_num
);
  pcw_lane_if #(.LANES(LANES)) lane_bus ();

  pcw_bus_t    st_r;
  logic        is_cfg;
  logic        req;
  logic [31:0] wmask;
  logic [31:0] status_word;
  logic [31:0] csr_rdata;
  logic [31:0] ctl_mask;
  logic [31:0] ctl_r;
  logic [31:0] ack_r;
  logic [31:0] pfrq_r;
  logic [31:0] nfrq_r;
  logic [31:0] cfrq_r;
  logic [31:0] tmr_r;
  logic [31:0] lnk_r;
  logic        wr_csr;
  logic [3:0]  lane_sync_w;
  logic [3:0]  idle_w;

  assign is_cfg = (i_wb_adr < CSR_BASE);
  assign req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_csr = req & i_wb_we & ~is_cfg & (st_r == BS_IDLE);

  // Byte lanes map straight to bits; lane 3 is the upper byte of N+2
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_wb_sel[b]}};
    end
  end

  // Sticky connection bits live in their own module
  assign lane_bus.conn_set = i_conn_detect;
  assign lane_bus.conn_clr = (wr_csr && i_wb_adr[12:2] == OFF_STATUS[12:2]) ?
                             i_wb_dat[STS_CONN_LSB +: LANES] & wmask[STS_CONN_LSB +: LANES]
                             : '0;

  pcw_conn_sticky #(.LANES(LANES)) u_conn (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .lane       (lane_bus.lane)
  );

  // Unused lanes padded with zeros so reserved bits read zero
  always_comb begin
    lane_sync_w = 4'h0;
    idle_w      = 4'h0;
    lane_sync_w[LANES-1:0] = i_lane_sync;
    idle_w[LANES-1:0]      = i_rx_elec_idle;
  end

  // Status word assembly; bits 31:24 and 2:0 stay zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_SYNC_LSB +: 4]  = lane_sync_w;
    status_word[STS_CONN_LSB +: 4]  = lane_bus.conn_sts;
    status_word[STS_IDLE_LSB +: 4]  = idle_w;
    status_word[STS_LTSSM_LSB +: 5] = i_ltssm_state;
    status_word[STS_DL_INACT]       = i_dl_state[3];
    status_word[STS_DL_INIT]        = i_dl_state[2];
    status_word[STS_DL_ACTIVE]      = i_dl_state[1];
    status_word[STS_DL_UP]          = i_dl_state[0];
  end

  // Control mask hides the loopback bits of absent lanes and bit 3
  always_comb begin
    ctl_mask = 32'h003f_ffff & ~CTL_RSVD;
    for (int l = LANES; l < 4; l++) begin
      ctl_mask[CTL_LOOP_LSB + l] = 1'b0;
    end
  end

  // CSR read mux, same byte order as writes
  always_comb begin
    unique case (i_wb_adr[12:2])
      OFF_STATUS[12:2]:     csr_rdata = status_word;
      OFF_FORCE_CTRL[12:2]: csr_rdata = ctl_r;
      OFF_ACK_TIMING[12:2]: csr_rdata = ack_r;
      OFF_POSTED_FRQ[12:2]: csr_rdata = pfrq_r;
      OFF_NONPST_FRQ[12:2]: csr_rdata = nfrq_r;
      OFF_CPL_FRQ[12:2]:    csr_rdata = cfrq_r;
      OFF_FC_TIMER[12:2]:   csr_rdata = tmr_r;
      default:              csr_rdata = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  // Link number is printed at an offset sharing the timer word; it gets the next word
  logic lnk_hit;
  assign lnk_hit = (i_wb_adr[12:2] == OFF_LINK_NUM[12:2] + 11'h001);

  // Control register; drives force and steering outputs through a one-cycle registered copy
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_r <= CTL_RESET;
    end else if (wr_csr && i_wb_adr[12:2] == OFF_FORCE_CTRL[12:2]) begin
      ctl_r <= ((ctl_r & ~wmask) | (i_wb_dat & wmask)) & ctl_mask;
    end
  end

  // Timing and frequency registers keep configured defaults after reset
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r  <= ACK_DEFAULT & ACK_MASK;
      pfrq_r <= PFRQ_DEF & FRQ_MASK;
      nfrq_r <= NFRQ_DEF & FRQ_MASK;
      cfrq_r <= CFRQ_DEF & FRQ_MASK;
      tmr_r  <= TMR_DEFAULT & TMR_MASK;
      lnk_r  <= 32'h0000_0000;
    end else if (wr_csr) begin
      if (i_wb_adr[12:2] == OFF_ACK_TIMING[12:2])
        ack_r  <= ((ack_r & ~wmask) | (i_wb_dat & wmask)) & ACK_MASK;
      if (i_wb_adr[12:2] == OFF_POSTED_FRQ[12:2])
        pfrq_r <= ((pfrq_r & ~wmask) | (i_wb_dat & wmask)) & FRQ_MASK;
      if (i_wb_adr[12:2] == OFF_NONPST_FRQ[12:2])
        nfrq_r <= ((nfrq_r & ~wmask) | (i_wb_dat & wmask)) & FRQ_MASK;
      if (i_wb_adr[12:2] == OFF_CPL_FRQ[12:2])
        cfrq_r <= ((cfrq_r & ~wmask) | (i_wb_dat & wmask)) & FRQ_MASK;
      if (i_wb_adr[12:2] == OFF_FC_TIMER[12:2])
        tmr_r  <= ((tmr_r & ~wmask) | (i_wb_dat & wmask)) & TMR_MASK;
      if (lnk_hit)
        lnk_r  <= ((lnk_r & ~wmask) | (i_wb_dat & wmask)) & LNK_MASK;
    end
  end

  // Bus slave: config accesses wait while the link owns config space
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= BS_IDLE;
    end else begin
      unique case (st_r)
        BS_IDLE:     if (req) st_r <= (is_cfg && i_link_cfg_busy) ? BS_CFG_WAIT : BS_ACK;
        BS_CFG_WAIT: if (!i_link_cfg_busy) st_r <= BS_ACK;
        BS_ACK:      st_r <= BS_IDLE;
        default:     st_r <= BS_IDLE;
      endcase
    end
  end

  // Ack and read data registered; config read packs bytes lowN, lowN+2, upN+2, upN
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= 1'b0;
      if (req && (st_r == BS_ACK || (st_r == BS_IDLE && !is_cfg))) begin
        o_wb_ack <= 1'b1;
        if (is_cfg)
          o_wb_dat <= {i_cfg_rd_lo[7:0], i_cfg_rd_hi[7:0], i_cfg_rd_hi[15:8],
                       i_cfg_rd_lo[15:8]};
        else if (lnk_hit)
          o_wb_dat <= lnk_r;
        else
          o_wb_dat <= csr_rdata;
      end
    end
  end

  // Config write strobe toward config space, taken once the link yields
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_wr     <= 1'b0;
      o_cfg_wr_adr <= 10'h000;
      o_cfg_wr_dat <= 32'h0000_0000;
      o_cfg_wr_sel <= 4'h0;
      o_cfg_rd_adr <= 10'h000;
    end else begin
      o_cfg_wr     <= req && is_cfg && i_wb_we && st_r == BS_ACK;
      o_cfg_wr_adr <= i_wb_adr[11:2];
      o_cfg_wr_dat <= i_wb_dat;
      o_cfg_wr_sel <= i_wb_sel;
      o_cfg_rd_adr <= i_wb_adr[11:2];
    end
  end

  // Registered copies for the core-side steering outputs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_force_ctrl     <= CTL_RESET;
      o_ack_fts_skp    <= 32'h0000_0000;
      o_posted_frq     <= 32'h0000_0000;
      o_nonposted_frq  <= 32'h0000_0000;
      o_completion_frq <= 32'h0000_0000;
      o_fc_timer       <= 12'h000;
      o_link_num       <= 8'h00;
    end else begin
      o_force_ctrl     <= ctl_r;
      o_ack_fts_skp    <= ack_r;
      o_posted_frq     <= pfrq_r;
      o_nonposted_frq  <= nfrq_r;
      o_completion_frq <= cfrq_r;
      o_fc_timer       <= tmr_r[11:0];
      o_link_num       <= lnk_r[7:0];
    end
  end

  cfg_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == BS_CFG_WAIT && i_link_cfg_busy) |=> !o_wb_ack)
    else $error("ack while link owns config");
  ctl_rsvd_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ctl_r[31:22] == 10'h000) && !ctl_r[3]) else $error("control reserved set");
  ctl_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr_csr && i_wb_adr[12:2] == OFF_FORCE_CTRL[12:2] && i_wb_sel == 4'hf)
    |=> ##1 o_force_ctrl == ($past(i_wb_dat, 2) & ctl_mask))
    else $error("control write not seen");
  csr_ack_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == BS_IDLE && req && !is_cfg) |=> o_wb_ack) else $error("csr ack late");
  frq_rsvd_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    pfrq_r[31:18] == 14'h0 && nfrq_r[31:18] == 14'h0 && cfrq_r[31:18] == 14'h0)
    else $error("frequency reserved set");
  sts_rsvd_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    status_word[31:24] == 8'h00 && status_word[2:0] == 3'h0)
    else $error("status reserved set");
  sts_state_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    status_word[11:7] == i_ltssm_state) else $error("state field wrong");
  cfg_order_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_wb_ack && $past(is_cfg) && !$past(i_wb_we)) |-> o_wb_dat[31:24] == $past(i_cfg_rd_lo[7:0]))
    else $error("config read order wrong");

  // A config access that meets a busy link must park in the wait state, never ack early
  cfg_stall_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_r == BS_IDLE && req && is_cfg && i_link_cfg_busy) |=> (st_r == BS_CFG_WAIT && !o_wb_ack))
    else $error("config access not stalled");
  // Ack is a single pulse; a held strobe would otherwise be taken twice
  ack_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  // Reserved bits of the timing, timer and link number words stay zero
  misc_rsvd_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    lnk_r[31:8] == 24'h00_0000 && ack_r[31:30] == 2'b00 && !ack_r[15] && tmr_r[31:12] == 20'h0_0000)
    else $error("timing reserved set");
  // Config write strobe and its acknowledge belong to the same cycle
  cfg_wr_pair_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_cfg_wr |-> o_wb_ack) else $error("config write without ack");

  // Main scenarios: stalled config access, control write, sticky clear, config write
  cfg_wait_c: cover property (@(posedge i_core_clk) st_r == BS_CFG_WAIT ##1 o_wb_ack);
  cfg_wr_c:   cover property (@(posedge i_core_clk) o_cfg_wr);
  ctl_wr_c:   cover property (@(posedge i_core_clk) wr_csr && i_wb_adr[12:2] == OFF_FORCE_CTRL[12:2]);
  sts_clr_c:  cover property (@(posedge i_core_clk) |lane_bus.conn_clr);
endmodule : pcw_csr_bank
`default_nettype wire

// ### pkg/pcw_pkg.sv
// Package for the endpoint Wishbone register window: offsets, fields, resets, states.
// Assumes a 32-bit Wishbone slave clocked by the core system clock.
package pcw_pkg;

  // Address map (byte addresses; cfg space below the CSR base)
  localparam logic [12:0] CSR_BASE       = 13'h1000;
  localparam logic [12:0] OFF_STATUS     = 13'h1008;
  localparam logic [12:0] OFF_FORCE_CTRL = 13'h100c;
  localparam logic [12:0] OFF_ACK_TIMING = 13'h1010;
  localparam logic [12:0] OFF_POSTED_FRQ = 13'h1014;
  localparam logic [12:0] OFF_NONPST_FRQ = 13'h1018;
  localparam logic [12:0] OFF_CPL_FRQ    = 13'h101c;
  localparam logic [12:0] OFF_FC_TIMER   = 13'h1020;
  // Printed offset is not word aligned; the word after the one holding it is decoded
  localparam logic [12:0] OFF_LINK_NUM   = 13'h1023;

  // Status register fields
  localparam int STS_SYNC_LSB   = 20;
  localparam int STS_CONN_LSB   = 16;
  localparam int STS_IDLE_LSB   = 12;
  localparam int STS_LTSSM_LSB  = 7;
  localparam int STS_DL_INACT   = 6;
  localparam int STS_DL_INIT    = 5;
  localparam int STS_DL_ACTIVE  = 4;
  localparam int STS_DL_UP      = 3;

  // Control register fields
  localparam int CTL_LOOP_LSB   = 18;
  localparam int CTL_DEBUG      = 17;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RSVD  = 32'h0000_0008; // Bit 3 always zero

  // Field masks of writable registers
  localparam logic [31:0] ACK_MASK  = 32'h3fff_7fff;
  localparam logic [31:0] FRQ_MASK  = 32'h0003_ffff;
  localparam logic [31:0] TMR_MASK  = 32'h0000_0fff;
  localparam logic [31:0] LNK_MASK  = 32'h0000_00ff;
  localparam int FRQ_HDR_LSB = 11;

  // Training state codes
  typedef enum logic [4:0] {
    LT_DETECT = 5'h00, LT_POLLING = 5'h01, LT_CONFIG = 5'h02, LT_L0 = 5'h03,
    LT_L0S = 5'h04, LT_L1 = 5'h05, LT_L2 = 5'h06, LT_RECOVERY = 5'h07,
    LT_LOOPBACK = 5'h08, LT_HOTRST = 5'h09, LT_DISABLED = 5'h0a
  } pcw_ltssm_t;

  // Bus slave states
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00, BS_CFG_WAIT = 2'b01, BS_ACK = 2'b10
  } pcw_bus_t;

endpackage : pcw_pkg

// ### pkg/pcw_lane_if.sv
// Interface carrying per-lane PHY status between the lane status module and the bank.
// Assumes one clock domain; lane count set by the bank.
`timescale 1ns/1ps
`default_nettype none
interface pcw_lane_if #(parameter int LANES = 4);
  logic [LANES-1:0] conn_set;   // Receiver detection hit, one cycle
  logic [LANES-1:0] conn_clr;   // Write-one clear request, one cycle
  logic [3:0]       conn_sts;   // Sticky connection bits, reserved lanes zero
  modport bank (output conn_set, output conn_clr, input conn_sts);
  modport lane (input conn_set, input conn_clr, output conn_sts);
endinterface : pcw_lane_if
`default_nettype wire

// ### logic/pcw_conn_sticky.sv
// Sticky receiver-detection connection bits, one per lane, clear on write.
// Assumes set and clear pulses are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module pcw_conn_sticky
  import pcw_pkg::*;
#(
  parameter int LANES = 4
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  pcw_lane_if.lane  lane
);
  logic [LANES-1:0] sts_r;

  // Set wins over clear so a detection in the clear cycle is kept
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sts_r <= '0;
    end else begin
      sts_r <= (sts_r & ~lane.conn_clr) | lane.conn_set;
    end
  end

  // Unused lanes read as zero
  always_comb begin
    lane.conn_sts = 4'h0;
    lane.conn_sts[LANES-1:0] = sts_r;
  end

  set_wins_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    lane.conn_set[0] |=> sts_r[0]) else $error("connection set lost");
endmodule : pcw_conn_sticky
`default_nettype wire

// ### verification/pcw_wb_master.sv
// Wishbone master model standing in for the user logic on the bank's bus side.
// Assumes the bank ends every cycle with a one-cycle registered acknowledge.
`timescale 1ns/1ps
`default_nettype none
module pcw_wb_master (
  input  wire logic        i_core_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output var  logic        o_cyc,
  output var  logic        o_stb,
  output var  logic        o_we,
  output var  logic [3:0]  o_sel,
  output var  logic [12:0] o_adr,
  output var  logic [31:0] o_dat
);
  // Idle bus; unqualified lines carry junk so stale values are never trusted
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_sel = 4'h0;
    o_adr = 13'h0aaa;
    o_dat = 32'h5a5a_a5a5;
  end

  // One access, held until acknowledge is sampled high, then released
  task automatic access(input logic we, input logic [12:0] adr, input logic [31:0] dat,
                        output logic [31:0] rdat, output int lat);
    lat = 0;
    @(posedge i_core_clk);
    #1;
    o_cyc = 1'b1;
    o_stb = 1'b1;
    o_we  = we;
    o_sel = 4'hf;
    o_adr = adr;
    o_dat = dat;
    do begin
      @(posedge i_core_clk);
      lat++;
    end while (i_ack !== 1'b1 && lat < 60); // Bounded so a dead slave cannot hang us
    rdat = i_dat;
    #1;
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_sel = 4'h0;
    o_adr = ~adr;
    o_dat = ~dat;
  endtask : access
endmodule : pcw_wb_master
`default_nettype wire

// ### verification/pcie_endpoint_wishbone_csr_bank_tb.sv
// Self-checking bench for the Wishbone register window, LFSR-driven stimulus.
// Assumes the bank package and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcie_endpoint_wishbone_csr_bank_tb;
  import pcw_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, busy, cfg_wr;
  logic [3:0]  sel, sync, conn, idle, dl, cfg_wr_sel, seen_sel;
  logic [4:0]  ltssm;
  logic [7:0]  link_num;
  logic [9:0]  cfg_wr_adr, cfg_rd_adr, seen_adr;
  logic [11:0] fc_tmr;
  logic [12:0] adr, ca;
  logic [15:0] cfg_lo, cfg_hi;
  logic [31:0] wdat, rdat, rd, r, seen_dat, force_ctrl, ack_fts, pfrq, nfrq, cfrq, cfg_wr_dat;
  logic [31:0] seed = 32'hcee7ee3d;
  int          lat;
  int          n_errors = 0;
  int          checked = 0;
  logic [12:0] offs [7] = '{OFF_FORCE_CTRL, OFF_ACK_TIMING, OFF_POSTED_FRQ, OFF_NONPST_FRQ,
                            OFF_CPL_FRQ, OFF_FC_TIMER, 13'h1024};
  logic [31:0] msk [7] = '{32'h003f_fff7, ACK_MASK, FRQ_MASK, FRQ_MASK, FRQ_MASK, TMR_MASK,
                           LNK_MASK};
  logic [31:0] wv [7];

  always #10 core_clk = ~core_clk;

  pcw_csr_bank #(.ACK_DEFAULT(32'hffff_ffff), .PFRQ_DEF(32'hffff_ffff),
    .NFRQ_DEF(32'hffff_ffff), .CFRQ_DEF(32'hffff_ffff), .TMR_DEFAULT(32'hffff_ffff)) u_pcw_csr_bank (
    .i_core_clk(core_clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_sel(sel), .i_wb_adr(adr), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_link_cfg_busy(busy), .i_cfg_rd_lo(cfg_lo), .i_cfg_rd_hi(cfg_hi), .o_cfg_wr(cfg_wr),
    .o_cfg_wr_adr(cfg_wr_adr), .o_cfg_wr_dat(cfg_wr_dat), .o_cfg_wr_sel(cfg_wr_sel),
    .o_cfg_rd_adr(cfg_rd_adr), .i_lane_sync(sync), .i_conn_detect(conn),
    .i_rx_elec_idle(idle), .i_ltssm_state(ltssm), .i_dl_state(dl), .o_force_ctrl(force_ctrl),
    .o_ack_fts_skp(ack_fts), .o_posted_frq(pfrq), .o_nonposted_frq(nfrq),
    .o_completion_frq(cfrq), .o_fc_timer(fc_tmr), .o_link_num(link_num));

  pcw_wb_master u_pcw_wb_master (.i_core_clk(core_clk), .i_ack(ack), .i_dat(rdat),
    .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_sel(sel), .o_adr(adr), .o_dat(wdat));

  // Capture config write pulses; they last one cycle only
  always @(posedge core_clk) begin
    if (cfg_wr === 1'b1) begin
      seen_dat <= cfg_wr_dat;
      seen_adr <= cfg_wr_adr;
      seen_sel <= cfg_wr_sel;
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Config reads swap bytes; the fourth byte position is the designer's pick
  function automatic logic [31:0] exp_cfg(input logic [15:0] lo, input logic [15:0] hi);
    return {lo[7:0], hi[7:0], hi[15:8], lo[15:8]};
  endfunction : exp_cfg

  function automatic logic [31:0] exp_status(input logic [3:0] c);
    return {8'h00, sync, c, idle, ltssm, dl, 3'b000};
  endfunction : exp_status

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    {busy, cfg_lo, cfg_hi, sync, conn, idle, ltssm, dl} = '0;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    // Reset values, masked write and read-back of every writable register
    for (int i = 0; i < 7; i++) begin
      u_pcw_wb_master.access(1'b0, offs[i], 32'h0, rd, lat);
      check(rd, (i == 0 || i == 6) ? 32'h0 : msk[i]);
      wv[i] = rnd();
      u_pcw_wb_master.access(1'b1, offs[i], wv[i], rd, lat);
      u_pcw_wb_master.access(1'b0, offs[i], 32'h0, rd, lat);
      check(rd, wv[i] & msk[i]);
    end
    repeat (2) @(posedge core_clk);
    check(ack_fts, wv[1] & ACK_MASK);
    check(pfrq, wv[2] & FRQ_MASK);
    check(nfrq, wv[3] & FRQ_MASK);
    check(cfrq, wv[4] & FRQ_MASK);
    check({20'h0, fc_tmr}, wv[5] & TMR_MASK);
    check({24'h0, link_num}, wv[6] & LNK_MASK);
    // Walking one over every control bit, reserved ones included
    for (int b = 0; b < 32; b++) begin
      u_pcw_wb_master.access(1'b1, OFF_FORCE_CTRL, 32'h1 << b, rd, lat);
      u_pcw_wb_master.access(1'b0, OFF_FORCE_CTRL, 32'h0, rd, lat);
      check(rd, (32'h1 << b) & msk[0]);
      check(force_ctrl, (32'h1 << b) & msk[0]);
    end
    // Status fields for every training state code
    for (int k = 0; k <= 10; k++) begin
      r = rnd();
      sync = r[3:0];
      idle = r[7:4];
      dl = r[11:8];
      ltssm = k[4:0];
      u_pcw_wb_master.access(1'b0, OFF_STATUS, 32'h0, rd, lat);
      check(rd, exp_status(4'h0));
    end
    // Sticky detection result, then write-one clear; a detection in the clear cycle wins
    @(posedge core_clk);
    #1 conn = 4'b0101;
    @(posedge core_clk);
    #1 conn = 4'b0000;
    u_pcw_wb_master.access(1'b0, OFF_STATUS, 32'h0, rd, lat);
    check(rd, exp_status(4'b0101));
    fork
      u_pcw_wb_master.access(1'b1, OFF_STATUS, 32'h000f_0000, rd, lat);
      begin
        @(posedge core_clk);
        #1 conn = 4'b0001;
        @(posedge core_clk);
        #1 conn = 4'b0000;
      end
    join
    u_pcw_wb_master.access(1'b0, OFF_STATUS, 32'h0, rd, lat);
    check(rd, exp_status(4'b0001));
    u_pcw_wb_master.access(1'b1, OFF_STATUS, 32'h0001_0000, rd, lat);
    u_pcw_wb_master.access(1'b0, OFF_STATUS, 32'h0, rd, lat);
    check(rd, exp_status(4'h0));
    // Config space: swapped read order, direct write order
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      cfg_lo = r[15:0];
      cfg_hi = r[31:16];
      ca = {1'b0, r[11:2], 2'b00};
      u_pcw_wb_master.access(1'b0, ca, 32'h0, rd, lat);
      check(rd, exp_cfg(r[15:0], r[31:16]));
      check({22'h0, cfg_rd_adr}, {22'h0, ca[11:2]});
      r = rnd();
      u_pcw_wb_master.access(1'b1, ca, r, rd, lat);
      check(seen_dat, r);
      check({22'h0, seen_adr}, {22'h0, ca[11:2]});
      check({28'h0, seen_sel}, 32'h0000_000f);
    end
    // Link config access holds off the Wishbone termination
    busy = 1'b1;
    fork
      u_pcw_wb_master.access(1'b0, 13'h0040, 32'h0, rd, lat);
      begin
        repeat (12) @(posedge core_clk);
        #1 busy = 1'b0;
      end
    join
    check({31'h0, lat > 12 && lat < 18}, 32'h1);
    // Unmapped CSR word reads zero and ignores writes
    u_pcw_wb_master.access(1'b1, CSR_BASE, rnd(), rd, lat);
    u_pcw_wb_master.access(1'b0, CSR_BASE, 32'h0, rd, lat);
    check(rd, 32'h0);
    // Reset in mid-run must bring control and posted frequency words back to reset values
    u_pcw_wb_master.access(1'b1, OFF_FORCE_CTRL, rnd() | 32'h0000_0001, rd, lat);
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    check(force_ctrl, CTL_RESET);
    u_pcw_wb_master.access(1'b0, OFF_FORCE_CTRL, 32'h0, rd, lat);
    check(rd, CTL_RESET);
    u_pcw_wb_master.access(1'b0, OFF_POSTED_FRQ, 32'h0, rd, lat);
    check(rd, FRQ_MASK);
    end_of_test();
  end
endmodule : pcie_endpoint_wishbone_csr_bank_tb
`default_nettype wire
